// *** lnb_host_ctrl.sv ***
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

module lnb_host_ctrl
	import lnb_host_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import lnb_host_pkg::*;

	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic go_q;
	cmd_type cmd_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_q;
	logic busy_q;
	logic done_q;
	logic nack_q;
	state_type state_q;
	kind_type kind_q;
	logic [1:0] phase_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	logic [2:0] rem_q;
	logic [1:0] bidx_q;
	logic [1:0] bidx_n;
	logic scl_oe_q;
	logic sda_oe_q;
	logic scl_out_q;
	logic sda_out_q;
	logic scl_s1_q;
	logic scl_s2_q;
	logic sda_s1_q;
	logic sda_s2_q;
	logic [DIV_WIDTH-1:0] div_q;
	logic tick_q;
	logic hold_stretch;
	logic apb_access;
	logic apb_answer;
	logic addr_hit;
	logic [2:0] go_count;
	logic bus_free_q;
	logic sda_oe_d1_q;

	// Reserved bits are forced to zero, and low power is dropped whenever
	// the same byte also enables the tone, so software slips cannot reach the link.
	function automatic logic [7:0] guard_byte(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] d;
		d = data;
		if (addr == OUTPUT_LEVEL_SELECT_ADDR) begin
			d = data & OUTPUT_LEVEL_MASK;
		end else if (addr == TONE_AND_POWER_CONTROL_ADDR) begin
			d = data & TONE_CONTROL_MASK;
			if (d[TONE_ENABLE_BIT]) begin
				d[LOW_POWER_MODE_BIT] = 1'b0;
			end
		end
		return d;
	endfunction : guard_byte

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign scl_out = scl_out_q;
	assign sda_out = sda_out_q;

	assign apb_answer = psel && penable && !pready_q;
	assign apb_access = psel && penable && pready_q;
	assign addr_hit = (paddr == CTRL_OFFSET) || (paddr == WDATA_OFFSET) ||
		(paddr == STATUS_OFFSET) || (paddr == RDATA_OFFSET);
	assign bidx_n = bidx_q + 2'd1;
	assign go_count = (pwdata[CTRL_COUNT_LSB +: 3] > COUNT_MAX) ? COUNT_MAX :
		pwdata[CTRL_COUNT_LSB +: 3];
	assign hold_stretch = (phase_q[1] == 1'b1) && !scl_oe_q && !scl_s2_q;

	// Open-drain pins only ever pull low; the level flops stay at zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_out_q <= 1'b0;
			sda_out_q <= 1'b0;
		end else begin
			scl_out_q <= 1'b0;
			sda_out_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
		end else begin
			scl_s1_q <= scl_in;
			scl_s2_q <= scl_s1_q;
			sda_s1_q <= sda_in;
			sda_s2_q <= sda_s1_q;
		end
	end

	// One wait state: the answer is computed while pready is still low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			go_q <= 1'b0;
			cmd_q <= CMD_RESET;
			wdata_q <= WDATA_RESET;
		end else begin
			pready_q <= apb_answer;
			go_q <= 1'b0;
			if (apb_answer) begin
				pslverr_q <= !addr_hit;
				prdata_q <= 32'h0000_0000;
				if (!pwrite) begin
					case (paddr)
						CTRL_OFFSET: prdata_q <= {8'h00, cmd_q.reg_addr, 1'b0, cmd_q.chip_addr,
							1'b0, cmd_q.count, 1'b0, cmd_q.skip_ack, cmd_q.read_op, 1'b0};
						WDATA_OFFSET: prdata_q <= wdata_q;
						STATUS_OFFSET: prdata_q <= {29'h0000_0000, nack_q, done_q, busy_q};
						RDATA_OFFSET: prdata_q <= rdata_q;
						default: prdata_q <= 32'h0000_0000;
					endcase
				end
			end
			if (apb_access && pwrite) begin
				if (paddr == WDATA_OFFSET) begin
					wdata_q <= pwdata;
				end
				// A go while busy is dropped so a frame is never disturbed.
				if (paddr == CTRL_OFFSET && !busy_q) begin
					cmd_q.reg_addr <= pwdata[CTRL_REG_LSB +: 8];
					cmd_q.chip_addr <= pwdata[CTRL_CHIP_LSB +: 7];
					cmd_q.count <= go_count;
					cmd_q.skip_ack <= pwdata[CTRL_SKIP_ACK_BIT];
					cmd_q.read_op <= pwdata[CTRL_READ_BIT];
					go_q <= pwdata[CTRL_GO_BIT];
				end
			end
		end
	end

	// Quarter-bit enable; a slave holding SCL low keeps the count cleared to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (!busy_q || hold_stretch) begin
				div_q <= '0;
			end else if (div_q == QUARTER_LAST) begin
				div_q <= '0;
				tick_q <= 1'b1;
			end else begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	// Sequencer. Each tick ends the quarter named by phase_q: SCL falls when
	// quarter 3 ends, SDA moves when quarter 0 ends, SCL rises when quarter 1 ends.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= st_idle;
			kind_q <= k_addr_w;
			phase_q <= 2'd0;
			bit_q <= 3'd0;
			shift_q <= 8'h00;
			rem_q <= 3'd0;
			bidx_q <= 2'd0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			rdata_q <= RDATA_RESET;
		end else if (state_q == st_idle) begin
			if (go_q) begin
				busy_q <= 1'b1;
				done_q <= 1'b0;
				nack_q <= 1'b0;
				state_q <= st_start;
				kind_q <= k_addr_w;
				phase_q <= 2'd0;
				bidx_q <= 2'd0;
				rem_q <= (cmd_q.read_op && cmd_q.count == 3'd0) ? 3'd1 : cmd_q.count;
			end
		end else if (tick_q) begin
			phase_q <= phase_q + 2'd1;
			case (state_q)
				st_start: begin
					if (phase_q == 2'd1) begin
						sda_oe_q <= 1'b1;
					end else if (phase_q == 2'd3) begin
						scl_oe_q <= 1'b1;
						shift_q <= {cmd_q.chip_addr, kind_q == k_addr_r};
						bit_q <= 3'd0;
						state_q <= st_tx_bit;
					end
				end
				st_tx_bit: begin
					if (phase_q == 2'd0) begin
						sda_oe_q <= !shift_q[7];
					end else if (phase_q == 2'd1) begin
						scl_oe_q <= 1'b0;
					end else if (phase_q == 2'd3) begin
						scl_oe_q <= 1'b1;
						shift_q <= {shift_q[6:0], 1'b0};
						bit_q <= bit_q + 3'd1;
						if (bit_q == 3'd7) begin
							state_q <= st_tx_ack;
						end
					end
				end
				st_tx_ack: begin
					if (phase_q == 2'd0) begin
						sda_oe_q <= 1'b0;
					end else if (phase_q == 2'd1) begin
						scl_oe_q <= 1'b0;
					end else if (phase_q == 2'd3) begin
						scl_oe_q <= 1'b1;
						bit_q <= 3'd0;
						if (sda_s2_q && !cmd_q.skip_ack) begin
							nack_q <= 1'b1;
							state_q <= st_stop;
						end else begin
							case (kind_q)
								k_addr_w: begin
									shift_q <= cmd_q.reg_addr;
									kind_q <= k_reg;
									state_q <= st_tx_bit;
								end
								k_reg: begin
									if (cmd_q.read_op || rem_q == 3'd0) begin
										state_q <= st_stop;
									end else begin
										shift_q <= guard_byte(cmd_q.reg_addr, wdata_q[7:0]);
										kind_q <= k_data;
										state_q <= st_tx_bit;
									end
								end
								k_data: begin
									bidx_q <= bidx_n;
									rem_q <= rem_q - 3'd1;
									if (rem_q == 3'd1) begin
										state_q <= st_stop;
									end else begin
										// The device advances its pointer, so byte n lands at base plus n.
										shift_q <= guard_byte(cmd_q.reg_addr + {6'h00, bidx_n},
											wdata_q[{bidx_n, 3'b000} +: 8]);
										state_q <= st_tx_bit;
									end
								end
								k_addr_r: begin
									kind_q <= k_read;
									state_q <= st_rx_bit;
								end
								default: state_q <= st_stop;
							endcase
						end
					end
				end
				st_rx_bit: begin
					if (phase_q == 2'd0) begin
						sda_oe_q <= 1'b0;
					end else if (phase_q == 2'd1) begin
						scl_oe_q <= 1'b0;
					end else if (phase_q == 2'd3) begin
						scl_oe_q <= 1'b1;
						shift_q <= {shift_q[6:0], sda_s2_q};
						bit_q <= bit_q + 3'd1;
						if (bit_q == 3'd7) begin
							state_q <= st_rx_ack;
						end
					end
				end
				st_rx_ack: begin
					if (phase_q == 2'd0) begin
						rdata_q[{bidx_q, 3'b000} +: 8] <= shift_q;
						sda_oe_q <= (rem_q > 3'd1);
					end else if (phase_q == 2'd1) begin
						scl_oe_q <= 1'b0;
					end else if (phase_q == 2'd3) begin
						scl_oe_q <= 1'b1;
						bit_q <= 3'd0;
						bidx_q <= bidx_n;
						rem_q <= rem_q - 3'd1;
						state_q <= (rem_q > 3'd1) ? st_rx_bit : st_stop;
					end
				end
				st_stop: begin
					if (phase_q == 2'd0) begin
						sda_oe_q <= 1'b1;
					end else if (phase_q == 2'd1) begin
						scl_oe_q <= 1'b0;
					end else if (phase_q == 2'd2) begin
						sda_oe_q <= 1'b0;
					end else begin
						// A read goes through a stop, never a repeated start.
						if (kind_q == k_reg && cmd_q.read_op && !nack_q) begin
							kind_q <= k_addr_r;
							state_q <= st_start;
						end else begin
							state_q <= st_idle;
							busy_q <= 1'b0;
							done_q <= 1'b1;
						end
					end
				end
				default: state_q <= st_idle;
			endcase
		end
	end

	// Tracks whether the last SDA edge under a high SCL was a stop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_free_q <= 1'b1;
			sda_oe_d1_q <= 1'b0;
		end else begin
			sda_oe_d1_q <= sda_oe_q;
			if (!scl_oe_q && sda_oe_q && !sda_oe_d1_q) begin
				bus_free_q <= 1'b0;
			end else if (!scl_oe_q && !sda_oe_q && sda_oe_d1_q) begin
				bus_free_q <= 1'b1;
			end
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_sda_steady_high: assert property (
		(state_q inside {st_tx_bit, st_tx_ack, st_rx_bit, st_rx_ack}) && !scl_oe_q &&
		!$past(scl_oe_q) |-> $stable(sda_oe_q))
		else $error("SDA moved while SCL was high inside a bit.");

	chk_start_form: assert property (
		$rose(sda_oe_q) && !scl_oe_q |-> state_q == st_start && phase_q == 2'd2)
		else $error("SDA fell under high SCL outside a start.");

	chk_stop_form: assert property (
		$fell(sda_oe_q) && !scl_oe_q |-> state_q == st_stop && phase_q == 2'd3)
		else $error("SDA rose under high SCL outside a stop.");

	chk_stop_before_start: assert property (
		$rose(sda_oe_q) && !scl_oe_q |-> bus_free_q)
		else $error("Start issued without a preceding stop.");

	chk_eight_bits: assert property (
		state_q == st_tx_ack && $past(state_q) == st_tx_bit |-> $past(bit_q) == 3'h7)
		else $error("Acknowledge slot did not follow eight bits.");

	chk_ack_release: assert property (
		state_q == st_tx_ack && phase_q != 2'd0 |-> !sda_oe_q)
		else $error("Master drove SDA during the slave acknowledge.");

	chk_nack_abort: assert property (
		tick_q && state_q == st_tx_ack && phase_q == 2'd3 && sda_s2_q && !cmd_q.skip_ack
		|=> state_q == st_stop && nack_q && scl_oe_q)
		else $error("Missing acknowledge did not lead to a stop.");

	chk_skip_ack: assert property (
		tick_q && state_q == st_tx_ack && phase_q == 2'd3 && cmd_q.skip_ack &&
		kind_q == k_addr_w |=> state_q == st_tx_bit && !nack_q)
		else $error("Unchecked acknowledge did not continue the frame.");

	chk_write_order: assert property (
		state_q == st_tx_bit && kind_q == k_data |-> !cmd_q.read_op)
		else $error("Data byte sent during a read command.");

	chk_stop_after_ack: assert property (
		state_q == st_stop && $past(state_q) != st_stop |->
		$past(state_q) inside {st_tx_ack, st_rx_ack})
		else $error("Stop did not follow an acknowledge slot.");

	chk_read_restart: assert property (
		state_q == st_start && $past(state_q) == st_stop |-> kind_q == k_addr_r && cmd_q.read_op)
		else $error("Second start without a pending read.");

	chk_read_end: assert property (
		state_q == st_rx_ack && phase_q != 2'd0 && rem_q == 3'd1 |-> !sda_oe_q)
		else $error("Last read byte was acknowledged low.");

endmodule : lnb_host_ctrl

// *** lnb_host_pkg.sv ***
package lnb_host_pkg;

	// Register map of the controller on the APB side.
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] WDATA_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] RDATA_OFFSET = 8'h0C;

	// Control word fields.
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_READ_BIT = 1;
	localparam int CTRL_SKIP_ACK_BIT = 2;
	localparam int CTRL_COUNT_LSB = 4;
	localparam int CTRL_CHIP_LSB = 8;
	localparam int CTRL_REG_LSB = 16;
	localparam logic [2:0] COUNT_MAX = 3'h4;

	// Status word fields.
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	localparam int STATUS_NACK_BIT = 2;

	// Device registers reached over the two-wire link.
	localparam logic [7:0] OUTPUT_LEVEL_SELECT_ADDR = 8'h02;
	localparam logic [7:0] TONE_AND_POWER_CONTROL_ADDR = 8'h03;
	localparam logic [7:0] OUTPUT_LEVEL_MASK = 8'h0F;
	localparam logic [7:0] TONE_CONTROL_MASK = 8'h07;
	localparam int TONE_ENABLE_BIT = 0;
	localparam int LOW_POWER_MODE_BIT = 1;
	localparam int EXTERNAL_TONE_SELECT_BIT = 2;
	localparam logic [7:0] DEVICE_REG_RESET = 8'h00;

	// Reset values of the controller's own registers.
	localparam logic [31:0] WDATA_RESET = 32'h0000_0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// Serial clock timing: one bit is four quarters.
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCL_QUARTER_NS = 250;
	localparam int QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_WIDTH = 9;
	localparam logic [DIV_WIDTH-1:0] QUARTER_LAST = DIV_WIDTH'(QUARTER_CYCLES - 1);

	typedef struct packed {
		logic [7:0] reg_addr;
		logic [6:0] chip_addr;
		logic [2:0] count;
		logic skip_ack;
		logic read_op;
	} cmd_type;

	localparam cmd_type CMD_RESET = '0;

	typedef enum {st_idle, st_start, st_tx_bit, st_tx_ack, st_rx_bit, st_rx_ack, st_stop} state_type;

	typedef enum {k_addr_w, k_reg, k_data, k_addr_r, k_read} kind_type;

endpackage : lnb_host_pkg

// *** lnb_dev_model.sv ***
`timescale 1ns/1ps

module lnb_dev_model #(
	parameter logic [6:0] CHIP = 7'h0A
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic uvlo,
	output logic sda_pull
);
	// Status registers 0 and 1 stay at zero; their contents are outside this block.
	logic [7:0] regs [256];
	logic [7:0] sh;
	logic [7:0] ptr;
	int st;
	int n;

	initial begin
		sda_pull = 1'b0;
		st = 0;
		n = 0;
		ptr = 8'h00;
		sh = 8'h00;
		for (int i = 0; i < 256; i++)
			regs[i] = 8'h00;
	end

	always @(negedge sda) begin
		if (scl === 1'b1) begin
			st = 1;
			n = -1;
			sda_pull = 1'b0;
		end
	end

	always @(posedge sda) begin
		if (scl === 1'b1) begin
			st = 0;
			sda_pull = 1'b0;
		end
	end

	always @(posedge scl) begin
		if (st >= 1 && st <= 3 && n >= 0 && n <= 7)
			sh = {sh[6:0], sda};
		if (st == 4 && n == 8 && sda === 1'b1)
			st = 0;
	end

	// Bit drive changes happen at the falling clock; only a start or stop seen under high SCL also releases the line.
	always @(negedge scl) begin
		if (st != 0) begin
			if (n == 7 && st == 4)
				sda_pull = 1'b0;
			else if (n == 7) begin
				if (uvlo || (st == 1 && sh[7:1] != CHIP))
					st = 0;
				else begin
					sda_pull = 1'b1;
					if (st == 3 && ptr > 8'h01)
						regs[ptr] = sh;
					if (st == 3)
						ptr = ptr + 8'h01;
					if (st == 2)
						ptr = sh;
					st = (st == 1) ? (sh[0] ? 5 : 2) : 3;
				end
			end else if (n == 8) begin
				sda_pull = 1'b0;
				if (st >= 4) begin
					sh = regs[ptr];
					ptr = ptr + 8'h01;
					st = 4;
					sda_pull = ~sh[7];
				end
			end else if (st == 4 && n >= 0)
				sda_pull = ~sh[6 - n];
			n = (n == 8) ? 0 : n + 1;
		end
	end
endmodule : lnb_dev_model

// *** lnb_i2c_slave_regs_test.sv ***
`timescale 1ns/1ps

module lnb_i2c_slave_regs_test;
	import lnb_host_pkg::*;
	localparam logic [6:0] CHIP = 7'h0A;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic scl_out, scl_oe, sda_out, sda_oe, sda_pull, scl_w, sda_w, uvlo, err, in_frame;
	logic [7:0] b0, b1;
	int fails, n_tests, seed;
	int dexp [256];

	assign scl_w = scl_oe ? scl_out : 1'b1;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

	lnb_host_ctrl lnb_host_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe));

	lnb_dev_model #(.CHIP(CHIP)) lnb_dev_model_i (.scl(scl_w), .sda(sda_w), .uvlo(uvlo),
		.sda_pull(sda_pull));

	always #2.5 pclk = ~pclk;

	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task chk_dev(input int a);
		n_tests++;
		if (lnb_dev_model_i.regs[a] !== 8'(dexp[a])) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, lnb_dev_model_i.regs[a], dexp[a]);
		end
	endtask : chk_dev

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait count is assumed; the watchdog ends a bus that never answers.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// The link runs at its real bit rate, so status is polled sparsely.
	task wait_done;
		int k;
		k = 0;
		do begin
			repeat (200) @(posedge pclk);
			apb(1'b0, STATUS_OFFSET, 32'h0);
			k++;
		end while (rd[STATUS_BUSY_BIT] !== 1'b0 && k < 2000);
	endtask : wait_done

	function automatic logic [31:0] cw(input logic r, input logic [2:0] c, input logic [7:0] ra);
		cw = (32'(ra) << CTRL_REG_LSB) | (32'(CHIP) << CTRL_CHIP_LSB) |
			(32'(c) << CTRL_COUNT_LSB) | (32'(r) << CTRL_READ_BIT) | (32'h1 << CTRL_GO_BIT);
	endfunction : cw

	task exp_store(input int a, input int v);
		if (a == 2)
			v = v & 'h0F;
		if (a == 3)
			v = (v & 'h01) ? (v & 'h05) : (v & 'h07);
		if (a > 1)
			dexp[a] = v;
	endtask : exp_store

	always @(negedge sda_w) begin
		if (scl_w === 1'b1) begin
			chk(32'(in_frame), 32'h0);
			in_frame = 1'b1;
		end
	end

	always @(posedge sda_w) begin
		if (scl_w === 1'b1)
			in_frame = 1'b0;
	end

	initial begin
		#400000;
		fails++;
		finish_test;
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		uvlo = 1'b0;
		in_frame = 1'b0;
		fails = 0;
		n_tests = 0;
		seed = 32'he34e;
		foreach (dexp[i])
			dexp[i] = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, WDATA_OFFSET, 32'h0);
		chk(rd, WDATA_RESET);
		apb(1'b0, RDATA_OFFSET, 32'h0);
		chk(rd, RDATA_RESET);
		apb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF);
		chk(32'(err), 32'h0);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		chk_dev(2);
		chk_dev(3);
		b0 = 8'($random(seed));
		b1 = 8'($random(seed)) | 8'h03;
		apb(1'b1, WDATA_OFFSET, {16'h0, b1, b0});
		exp_store(2, b0);
		exp_store(3, b1);
		apb(1'b1, CTRL_OFFSET, cw(1'b0, 3'h2, 8'h02));
		apb(1'b1, CTRL_OFFSET, cw(1'b0, 3'h1, 8'h05));
		wait_done;
		chk(rd, 32'h2);
		chk_dev(2);
		chk_dev(3);
		chk_dev(5);
		apb(1'b1, CTRL_OFFSET, cw(1'b1, 3'h2, 8'h02));
		wait_done;
		chk(rd, 32'h2);
		apb(1'b0, RDATA_OFFSET, 32'h0);
		chk(rd, {16'h0, 8'(dexp[3]), 8'(dexp[2])});
		apb(1'b1, WDATA_OFFSET, {24'h0, 8'(dexp[3]) ^ 8'h04});
		uvlo <= 1'b1;
		apb(1'b1, CTRL_OFFSET, cw(1'b0, 3'h1, 8'h03));
		wait_done;
		chk(rd, 32'h6);
		chk_dev(3);
		apb(1'b1, CTRL_OFFSET, cw(1'b0, 3'h1, 8'h03) | (32'h1 << CTRL_SKIP_ACK_BIT));
		wait_done;
		chk(rd, 32'h2);
		chk_dev(3);
		uvlo <= 1'b0;
		apb(1'b1, CTRL_OFFSET, cw(1'b0, 3'h1, 8'h03) ^ (32'h1 << CTRL_CHIP_LSB));
		wait_done;
		chk(rd, 32'h6);
		chk_dev(3);
		apb(1'b1, CTRL_OFFSET, cw(1'b0, 3'h1, 8'h03));
		wait_done;
		chk(rd, 32'h2);
		exp_store(3, dexp[3] ^ 'h04);
		chk_dev(3);
		finish_test;
	end
endmodule : lnb_i2c_slave_regs_test
